// ==== logic/tcc_thermal_ctrl.sv ====
// Purpose: Configuration-driven supervision of a temperature controller
// Assumes: Sensor values are corrected, signed tenths of a degree, synchronous to sys_clk
// Notes:   The control law itself sits outside; this block gates, limits and ramps
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_thermal_ctrl
	import tcc_pkg::*;
#(
	parameter int RAMP_TICK_CYC = `TCC_RAMP_TICK_CYC,
	parameter int SLOW_STEP_CYC = `TCC_SLOW_STEP_CYC,
	parameter int FAN_UNIT_CYC  = `TCC_FAN_UNIT_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              config_mode,
	input  wire logic              sample_valid,
	input  wire tcc_temp_t         sensor1_temp,
	input  wire tcc_temp_t         sensor2_temp,
	input  wire tcc_temp_t         sensor3_temp,
	input  wire logic [2:0]        filter_sel,
	input  wire logic [1:0]        sensor_sel,
	input  wire logic              heater_mode,
	input  wire tcc_aux_in_mode_t  aux_in_mode,
	input  wire logic              aux_in,
	input  wire tcc_aux_out_mode_t aux_out_mode,
	input  wire tcc_temp_t         set_value1,
	input  wire tcc_temp_t         set_value2,
	input  wire logic [6:0]        tolerance_range,
	input  wire logic [6:0]        alarm_range,
	input  wire logic [6:0]        proportional_gain_entry,
	input  wire logic [6:0]        integral_gain_entry,
	input  wire logic [6:0]        derivative_gain_entry,
	input  wire logic [9:0]        integral_clamp_entry,
	input  wire logic [7:0]        pwm_limit_entry,
	input  wire logic [6:0]        power_demand,
	input  wire logic [6:0]        ramp_rate,
	input  wire tcc_temp_t         s2_limit,
	input  wire tcc_temp_t         s3_limit,
	input  wire logic              s2_offset_neg,
	input  wire logic [6:0]        s2_offset_mag,
	input  wire logic              s3_offset_neg,
	input  wire logic [6:0]        s3_offset_mag,
	input  wire tcc_temp_t         fan_lower,
	input  wire tcc_temp_t         fan_upper,
	input  wire logic [6:0]        fan_hyst,
	input  wire logic [6:0]        fan_delay,
	input  wire tcc_temp_t         dz_lower,
	input  wire tcc_temp_t         dz_upper,
	input  wire logic [6:0]        dz_hyst,
	input  wire logic [8:0]        supply_voltage,
	input  wire logic [8:0]        supply_lower,
	input  wire logic [8:0]        supply_upper,
	output logic [5:0]             filter_seconds,
	output tcc_sensor_kind_t       sensor_kind,
	output logic [5:0]             proportional_gain,
	output logic [5:0]             integral_gain,
	output logic [5:0]             derivative_gain,
	output logic [13:0]            integral_clamp,
	output logic [6:0]             pwm_limit,
	output tcc_temp_t              setpoint_internal,
	output tcc_temp_t              s2_corrected,
	output tcc_temp_t              s3_corrected,
	output logic                   use_set_value2,
	output logic                   control_enable,
	output logic                   power_out,
	output logic                   range_error,
	output logic                   supply_fault,
	output logic                   sensor_fault,
	output logic                   limit_cfg_error,
	output logic                   aux_out,
	output logic                   dead_zone_inside,
	output logic                   fan_on
);
	tcc_state_t cur;
	tcc_state_t next_cur;
	logic       fan_level;

	// Sign-magnitude offset to signed tenths, never negative zero
	function automatic tcc_temp_t offset_val(input logic neg, input logic [6:0] mag);
		tcc_temp_t v;
		v = tcc_temp_t'({9'h000, mag});
		if (neg && mag == 7'h00) begin
			v = `TCC_OFFSET_NEG_ZERO;
		end else if (neg) begin
			v = -v;
		end
		return v;
	endfunction

	// Limit check: disabled code, rejected band, or live compare
	function automatic logic lim_rejected(input tcc_temp_t lim);
		return (lim >= `TCC_TEMP_REJ_LO) && (lim <= `TCC_TEMP_REJ_HI);
	endfunction

	function automatic logic sens_bad(input tcc_temp_t val, input tcc_temp_t lim);
		logic off;
		off = (lim == `TCC_TEMP_DISABLE) || lim_rejected(lim);
		return !off && ((val > lim) || (val < `TCC_TEMP_RANGE_LO) || (val > `TCC_TEMP_RANGE_HI));
	endfunction

	tcc_temp_t nominal;
	tcc_temp_t dev;
	tcc_temp_t dz_h;
	tcc_temp_t fan_h;
	logic      dz_disabled;
	logic      aux_gate;
	logic      dz_gate;
	logic [6:0] duty;
	logic      slow_mode;
	logic      next_use_sv2_sel;

	// Working values shared by the state update
	always_comb begin
		dz_h        = tcc_temp_t'({9'h000, dz_hyst});
		fan_h       = tcc_temp_t'({9'h000, fan_hyst});
		dz_disabled = (dz_lower == `TCC_TEMP_DISABLE) || (dz_upper == `TCC_TEMP_DISABLE);
		// Dual mode wins over the dead zone for the set value choice
		if (aux_in_mode == TCC_AUXIN_DUAL) begin
			next_use_sv2_sel = aux_in;
		end else begin
			next_use_sv2_sel = !dz_disabled && (cur.dz == TCC_DZ_HIGH);
		end
		nominal = next_use_sv2_sel ? set_value2 : set_value1;
		dev     = sensor1_temp - cur.sp;
		if (dev < 0) begin
			dev = -dev;
		end
		unique case (aux_in_mode)
			TCC_AUXIN_OFF:  aux_gate = !aux_in;
			TCC_AUXIN_ON:   aux_gate = aux_in;
			default:        aux_gate = 1'b1;
		endcase
		dz_gate   = dz_disabled || (cur.dz != TCC_DZ_OFF);
		duty      = (power_demand < cur.pwm_lim) ? power_demand : cur.pwm_lim;
		slow_mode = heater_mode && (cur.pwm_lim == `TCC_PWM_LIM_SLOW);
	end

	// Full next-state computation
	always_comb begin
		next_cur = cur;

		// Configuration decode
		unique case (filter_sel)
			3'h0:    next_cur.filt_s = `TCC_FILT_0;
			3'h1:    next_cur.filt_s = `TCC_FILT_1;
			3'h2:    next_cur.filt_s = `TCC_FILT_2;
			3'h3:    next_cur.filt_s = `TCC_FILT_3;
			3'h4:    next_cur.filt_s = `TCC_FILT_4;
			3'h5:    next_cur.filt_s = `TCC_FILT_5;
			default: next_cur.filt_s = cur.filt_s; // Unused codes keep the last constant
		endcase
		next_cur.kind = tcc_sensor_kind_t'(sensor_sel);
		// Over-range entries fall back to zero, which also switches the term off
		next_cur.pgain = (proportional_gain_entry > `TCC_GAIN_MAX) ? 6'h00
			: proportional_gain_entry[5:0];
		next_cur.igain = (integral_gain_entry > `TCC_GAIN_MAX) ? 6'h00
			: integral_gain_entry[5:0];
		next_cur.dgain = (derivative_gain_entry > `TCC_GAIN_MAX) ? 6'h00
			: derivative_gain_entry[5:0];
		next_cur.clamp = (integral_clamp_entry > `TCC_CLAMP_MAX) ? 14'h0000
			: 14'({4'h0, integral_clamp_entry} * `TCC_CLAMP_SCALE);
		if (next_cur.clamp == 14'h0000) begin
			next_cur.igain = 6'h00;
		end
		next_cur.pwm_lim = (pwm_limit_entry > `TCC_PWM_LIM_MAX) ? 7'h00
			: pwm_limit_entry[6:0];

		// Sensor correction and supervision
		next_cur.s2c = sensor2_temp + offset_val(s2_offset_neg, s2_offset_mag);
		next_cur.s3c = sensor3_temp + offset_val(s3_offset_neg, s3_offset_mag);
		next_cur.sens_err    = sens_bad(cur.s2c, s2_limit) || sens_bad(cur.s3c, s3_limit);
		next_cur.lim_cfg_err = lim_rejected(s2_limit) || lim_rejected(s3_limit);
		next_cur.range_err   = (sensor1_temp < `TCC_TEMP_RANGE_LO)
			|| (sensor1_temp > `TCC_TEMP_RANGE_HI);
		next_cur.supply_err  = (supply_voltage < supply_lower)
			|| (supply_voltage > supply_upper);

		// Set point ramp, paced by a millisecond tick and a per-minute accumulator
		if (!cur.sp_init) begin
			if (sample_valid) begin
				next_cur.sp      = sensor1_temp;
				next_cur.sp_init = 1'b1;
			end
		end else if (ramp_rate == 7'h00) begin
			next_cur.sp       = nominal;
			next_cur.acc      = 17'h00000;
			next_cur.tick_cnt = 17'h00000;
		end else if (cur.tick_cnt == 17'(RAMP_TICK_CYC - 1)) begin
			next_cur.tick_cnt = 17'h00000;
			if (cur.acc + {10'h000, ramp_rate} >= `TCC_RAMP_MS_PER_MIN) begin
				next_cur.acc = cur.acc + {10'h000, ramp_rate} - `TCC_RAMP_MS_PER_MIN;
				if (cur.sp < nominal) begin
					next_cur.sp = cur.sp + 16'sh0001;
				end else if (cur.sp > nominal) begin
					next_cur.sp = cur.sp - 16'sh0001;
				end
			end else begin
				next_cur.acc = cur.acc + {10'h000, ramp_rate};
			end
		end else begin
			next_cur.tick_cnt = cur.tick_cnt + 17'h00001;
		end

		// Dead zone on corrected sensor 2
		unique case (cur.dz)
			TCC_DZ_OFF: begin
				if (cur.s2c < dz_lower - dz_h) begin
					next_cur.dz = TCC_DZ_LOW;
				end else if (cur.s2c > dz_upper + dz_h) begin
					next_cur.dz = TCC_DZ_HIGH;
				end
			end
			TCC_DZ_LOW: begin
				if (cur.s2c > dz_lower + dz_h) begin
					next_cur.dz = TCC_DZ_OFF;
				end
			end
			TCC_DZ_HIGH: begin
				if (cur.s2c < dz_upper - dz_h) begin
					next_cur.dz = TCC_DZ_OFF;
				end
			end
			default: next_cur.dz = TCC_DZ_OFF;
		endcase
		if (dz_disabled) begin
			next_cur.dz = TCC_DZ_OFF;
		end
		next_cur.dz_inside = !dz_disabled && (next_cur.dz == TCC_DZ_OFF);

		// Fan request with hysteresis on sensor 3, independent of the dead zone
		if (cur.s3c > fan_upper + fan_h) begin
			next_cur.fan_req = 1'b1;
		end else if (cur.s3c < fan_lower - fan_h) begin
			next_cur.fan_req = 1'b0;
		end

		// PWM time bases run freely so a duty change takes effect mid-period
		next_cur.pwm_cnt = cur.pwm_cnt + 7'h01;
		if (cur.slow_cnt == 22'(SLOW_STEP_CYC - 1)) begin
			next_cur.slow_cnt  = 22'h000000;
			next_cur.slow_step = cur.slow_step + 4'h1;
		end else begin
			next_cur.slow_cnt = cur.slow_cnt + 22'h000001;
		end

		// Output gating
		next_cur.use_sv2 = next_use_sv2_sel;
		next_cur.ctl_en  = !config_mode && aux_gate && dz_gate && cur.sp_init;
		if (!next_cur.ctl_en || cur.range_err || cur.supply_err || cur.sens_err
			|| (cur.pwm_lim == 7'h00)) begin
			next_cur.power = 1'b0;
		end else if (slow_mode) begin
			next_cur.power = cur.slow_step < power_demand[6:3];
		end else begin
			next_cur.power = cur.pwm_cnt < duty;
		end
		if (config_mode) begin
			next_cur.aux_out = 1'b0;
		end else if (aux_out_mode == TCC_AUXOUT_OUT_OF_BAND) begin
			next_cur.aux_out = dev > tcc_temp_t'({9'h000, alarm_range});
		end else begin
			next_cur.aux_out = dev <= tcc_temp_t'({9'h000, tolerance_range});
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur        <= '0;
			cur.filt_s <= `TCC_RST_FILT;
			cur.sp     <= `TCC_RST_TEMP;
		end else begin
			cur <= next_cur;
		end
	end

	// Fan switching delay in 250 ms units
	tcc_persist #(
		.UNIT_CYC (FAN_UNIT_CYC)
	) u_fan_delay (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.request     (cur.fan_req),
		.delay_units (fan_delay),
		.level       (fan_level)
	);

	// Outputs
	assign filter_seconds    = cur.filt_s;
	assign sensor_kind       = cur.kind;
	assign proportional_gain = cur.pgain;
	assign integral_gain     = cur.igain;
	assign derivative_gain   = cur.dgain;
	assign integral_clamp    = cur.clamp;
	assign pwm_limit         = cur.pwm_lim;
	assign setpoint_internal = cur.sp;
	assign s2_corrected      = cur.s2c;
	assign s3_corrected      = cur.s3c;
	assign use_set_value2    = cur.use_sv2;
	assign control_enable    = cur.ctl_en;
	assign power_out         = cur.power;
	assign range_error       = cur.range_err;
	assign supply_fault      = cur.supply_err;
	assign sensor_fault      = cur.sens_err;
	assign limit_cfg_error   = cur.lim_cfg_err;
	assign aux_out           = cur.aux_out;
	assign dead_zone_inside  = cur.dz_inside;
	assign fan_on            = fan_level && !config_mode;
endmodule

// ==== logic/tcc_map.svh ====
// Purpose: Offsets, field codes, reset values and timing counts of the thermal control logic
// Assumes: 100 MHz system clock; temperatures in signed tenths of a degree
// Notes:   Definitions only
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// Clock and time bases
`define TCC_CLK_HZ          100000000
`define TCC_RAMP_TICK_MS    1
`define TCC_RAMP_TICK_CYC   ((`TCC_CLK_HZ / 1000) * `TCC_RAMP_TICK_MS)
`define TCC_RAMP_MS_PER_MIN 17'h0ea60
`define TCC_SLOW_PWM_HZ     3
`define TCC_SLOW_PWM_STEPS  16
`define TCC_SLOW_STEP_CYC   (`TCC_CLK_HZ / (`TCC_SLOW_PWM_HZ * `TCC_SLOW_PWM_STEPS))
`define TCC_FAN_UNIT_MS     250
`define TCC_FAN_UNIT_CYC    ((`TCC_CLK_HZ / 1000) * `TCC_FAN_UNIT_MS)

// Entry limits
`define TCC_GAIN_MAX        7'h3f
`define TCC_CLAMP_MAX       10'h3e7
`define TCC_CLAMP_SCALE     14'h000a
`define TCC_PWM_LIM_MAX     8'h7f
`define TCC_PWM_LIM_SLOW    7'h01
`define TCC_FAN_DLY_MAX     7'h78

// Temperature codes, tenths of a degree
`define TCC_TEMP_DISABLE    16'shfc19
`define TCC_TEMP_REJ_LO     16'shfc1a
`define TCC_TEMP_REJ_HI     16'shfd12
`define TCC_TEMP_RANGE_LO   16'shfd12
`define TCC_TEMP_RANGE_HI   16'sh06d6
`define TCC_OFFSET_NEG_ZERO 16'shffff

// Filter time constants in seconds, selector 0 to 5
`define TCC_FILT_0          6'h01
`define TCC_FILT_1          6'h02
`define TCC_FILT_2          6'h05
`define TCC_FILT_3          6'h0a
`define TCC_FILT_4          6'h14
`define TCC_FILT_5          6'h32

// Reset values
`define TCC_RST_TEMP        16'sh0000
`define TCC_RST_FILT        6'h01

`endif

// ==== logic/tcc_pkg.sv ====
// Purpose: Types shared by the thermal control logic
// Assumes: Constants live in tcc_map.svh
// Notes:   Temperatures are signed tenths of a degree
package tcc_pkg;

	typedef logic signed [15:0] tcc_temp_t;

	typedef enum logic [1:0] {
		TCC_SENS_PT100   = 2'h0,
		TCC_SENS_PT1000  = 2'h1,
		TCC_SENS_SPECIAL = 2'h2,
		TCC_SENS_BAD     = 2'h3
	} tcc_sensor_kind_t;

	typedef enum logic [1:0] {
		TCC_AUXIN_OFF  = 2'h0,
		TCC_AUXIN_ON   = 2'h1,
		TCC_AUXIN_DUAL = 2'h2,
		TCC_AUXIN_RSVD = 2'h3
	} tcc_aux_in_mode_t;

	typedef enum logic {
		TCC_AUXOUT_OUT_OF_BAND = 1'b0,
		TCC_AUXOUT_GOOD        = 1'b1
	} tcc_aux_out_mode_t;

	typedef enum logic [1:0] {
		TCC_DZ_OFF,
		TCC_DZ_LOW,
		TCC_DZ_HIGH
	} tcc_dz_state_t;

	typedef struct packed {
		logic [6:0]  cnt;
		logic [24:0] unit_cnt;
		logic        level;
	} tcc_persist_state_t;

	typedef struct packed {
		tcc_temp_t        sp;
		logic             sp_init;
		logic [16:0]      tick_cnt;
		logic [16:0]      acc;
		tcc_dz_state_t    dz;
		logic             fan_req;
		logic [6:0]       pwm_cnt;
		logic [21:0]      slow_cnt;
		logic [3:0]       slow_step;
		logic [5:0]       filt_s;
		tcc_sensor_kind_t kind;
		logic [5:0]       pgain;
		logic [5:0]       igain;
		logic [5:0]       dgain;
		logic [13:0]      clamp;
		logic [6:0]       pwm_lim;
		tcc_temp_t        s2c;
		tcc_temp_t        s3c;
		logic             ctl_en;
		logic             power;
		logic             use_sv2;
		logic             range_err;
		logic             supply_err;
		logic             sens_err;
		logic             lim_cfg_err;
		logic             aux_out;
		logic             dz_inside;
	} tcc_state_t;

endpackage

// ==== logic/tcc_persist.sv ====
// Purpose: Passes a requested level on only after it has stood for a set number of time units
// Assumes: Request is synchronous to sys_clk
// Notes:   A delay of zero follows the request on the next edge
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_persist
	import tcc_pkg::*;
#(
	parameter int UNIT_CYC = `TCC_FAN_UNIT_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       request,
	input  wire logic [6:0] delay_units,
	output logic            level
);
	tcc_persist_state_t cur;
	tcc_persist_state_t next_cur;

	// Timer restarts whenever the request agrees with the output again
	always_comb begin
		next_cur = cur;
		if (request == cur.level) begin
			next_cur.cnt      = 7'h00;
			next_cur.unit_cnt = 25'h0000000;
		end else if (cur.cnt >= delay_units) begin
			next_cur.level    = request;
			next_cur.cnt      = 7'h00;
			next_cur.unit_cnt = 25'h0000000;
		end else if (cur.unit_cnt == 25'(UNIT_CYC - 1)) begin
			next_cur.unit_cnt = 25'h0000000;
			next_cur.cnt      = cur.cnt + 7'h01;
		end else begin
			next_cur.unit_cnt = cur.unit_cnt + 25'h0000001;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign level = cur.level;
endmodule

// ==== dv/tcc_thermal_ctrl_monitor.sv ====
// Purpose: Port-level property checks for the thermal control logic
// Assumes: One clock, synchronous active-high reset, registered outputs one clock late
// Notes:   Bound to the design after the module
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_thermal_ctrl_monitor
	import tcc_pkg::*;
(
	input wire logic             sys_clk,
	input wire logic             rst,
	input wire logic             config_mode,
	input wire tcc_aux_in_mode_t aux_in_mode,
	input wire logic             aux_in,
	input wire tcc_temp_t        sensor1_temp,
	input wire logic [8:0]       supply_voltage,
	input wire logic [8:0]       supply_lower,
	input wire logic [8:0]       supply_upper,
	input wire logic [2:0]       filter_sel,
	input wire logic [1:0]       sensor_sel,
	input wire logic [6:0]       proportional_gain_entry,
	input wire logic [9:0]       integral_clamp_entry,
	input wire logic [7:0]       pwm_limit_entry,
	input wire logic [5:0]       filter_seconds,
	input wire tcc_sensor_kind_t sensor_kind,
	input wire logic [5:0]       proportional_gain,
	input wire logic [5:0]       integral_gain,
	input wire logic [13:0]      integral_clamp,
	input wire logic [6:0]       pwm_limit,
	input wire logic             use_set_value2,
	input wire logic             control_enable,
	input wire logic             power_out,
	input wire logic             range_error,
	input wire logic             supply_fault,
	input wire logic             fan_on
);
	localparam logic [5:0] FT [6] = '{6'h01, 6'h02, 6'h05, 6'h0a, 6'h14, 6'h32};
	// Fault causes seen at the inputs
	wire logic oor = sensor1_temp < `TCC_TEMP_RANGE_LO || sensor1_temp > `TCC_TEMP_RANGE_HI;
	wire logic sup_bad = supply_voltage < supply_lower || supply_voltage > supply_upper;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Supply trip: flag next clock, output stage off the clock after
	sequence s_supply_trip;
		sup_bad ##1 supply_fault ##1 !power_out;
	endsequence

	a_filter_map: assert property (!$past(rst) && $past(filter_sel) < 3'h6 |->
		filter_seconds == FT[$past(filter_sel)]) else $error("filter constant wrong");
	a_sensor_code: assert property (!$past(rst) |-> sensor_kind == $past(sensor_sel))
		else $error("sensor kind wrong");
	a_off_gate: assert property (aux_in_mode == TCC_AUXIN_OFF && aux_in |=> !control_enable)
		else $error("switch-off input ignored");
	a_on_gate: assert property (aux_in_mode == TCC_AUXIN_ON && !aux_in |=> !control_enable)
		else $error("switch-on input ignored");
	a_dual_pick: assert property (!$past(rst) && $past(aux_in_mode) == TCC_AUXIN_DUAL |->
		use_set_value2 == $past(aux_in)) else $error("dual set value wrong");
	a_gain_wrap: assert property (!$past(rst) |-> proportional_gain ==
		6'($past(proportional_gain_entry) > 7'h3f ? 7'h00 : $past(proportional_gain_entry)))
		else $error("gain wrap wrong");
	a_clamp_scale: assert property (!$past(rst) |-> integral_clamp ==
		($past(integral_clamp_entry) > 10'h3e7 ? 14'h0000 : 14'($past(integral_clamp_entry)) * 14'h000a))
		else $error("clamp scale wrong");
	a_clamp_zero: assert property (integral_clamp == 14'h0000 |-> integral_gain == 6'h00)
		else $error("integral not disabled");
	a_pwm_wrap: assert property (!$past(rst) |-> pwm_limit ==
		7'($past(pwm_limit_entry) > 8'h7f ? 8'h00 : $past(pwm_limit_entry)))
		else $error("pwm limit wrong");
	a_pwm_zero: assert property (pwm_limit == 7'h00 [*2] |-> !power_out)
		else $error("power with zero limit");
	a_supply_trip: assert property (sup_bad |-> s_supply_trip)
		else $error("supply trip missed");
	a_range_flag: assert property (!$past(rst) |-> range_error == $past(oor))
		else $error("range flag wrong");
	a_range_kill: assert property (range_error |=> !power_out)
		else $error("power during range error");
	a_config_quiet: assert property (config_mode [*2] |=> !power_out && !control_enable)
		else $error("outputs active in configuration");
	a_fan_config: assert property (config_mode |-> !fan_on)
		else $error("fan on in configuration");
endmodule
bind tcc_thermal_ctrl tcc_thermal_ctrl_monitor u_tcc_thermal_ctrl_monitor (.sys_clk, .rst,
	.config_mode, .aux_in_mode, .aux_in, .sensor1_temp, .supply_voltage, .supply_lower,
	.supply_upper, .filter_sel, .sensor_sel, .proportional_gain_entry, .integral_clamp_entry,
	.pwm_limit_entry, .filter_seconds, .sensor_kind, .proportional_gain, .integral_gain,
	.integral_clamp, .pwm_limit, .use_set_value2, .control_enable, .power_out, .range_error,
	.supply_fault, .fan_on);

// ==== dv/tcc_far_side.sv ====
// Purpose: Far-side model: three sensors, output-stage supply and a load counting on-clocks
// Assumes: Goals come from the bench
// Notes:   Values lag their goals by one clock, like a sampled converter
`timescale 1ns/1ps
module tcc_far_side
	import tcc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire tcc_temp_t  t1_goal,
	input  wire tcc_temp_t  t2_goal,
	input  wire tcc_temp_t  t3_goal,
	input  wire logic [8:0] volt_goal,
	input  wire logic       power_out,
	input  wire logic       clr,
	output tcc_temp_t       s1,
	output tcc_temp_t       s2,
	output tcc_temp_t       s3,
	output logic [8:0]      volts,
	output int unsigned     on_cycles
);
	// Known values before the first edge so reset sees no unknowns
	initial begin
		{s1, s2, s3} = '0;
		volts = 9'h0f0;
		on_cycles = 0;
	end
	// Sensors and supply settle just after the edge
	always @(posedge sys_clk) begin
		s1 <= #1 t1_goal;
		s2 <= #1 t2_goal;
		s3 <= #1 t3_goal;
		volts <= #1 volt_goal;
	end
	// Load counts clocks with the output stage on
	always @(posedge sys_clk)
		on_cycles <= clr ? 0 : on_cycles + 32'(power_out);
endmodule

// ==== dv/tb_top.sv ====
// Purpose: Directed tests of the thermal control logic
// Assumes: Short time bases: ramp tick 10, slow step 4, fan unit 5 clocks
// Notes:   Inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`include "tcc_map.svh"
module tb_top;
	import tcc_pkg::*;
	logic              sys_clk = 0, rst = 1, config_mode = 0, sample_valid = 0, heater_mode = 0;
	logic              aux_in = 0, s2_offset_neg = 0, s3_offset_neg = 0, clr = 0;
	logic [2:0]        filter_sel = 3'h0;
	logic [1:0]        sensor_sel = 2'h0;
	tcc_aux_in_mode_t  aux_in_mode = TCC_AUXIN_OFF;
	tcc_aux_out_mode_t aux_out_mode = TCC_AUXOUT_OUT_OF_BAND;
	tcc_temp_t         set_value1 = 16'sh012c, set_value2 = 16'sh015e, fan_lower = 16'sh00c8;
	tcc_temp_t         s2_limit = `TCC_TEMP_DISABLE, s3_limit = `TCC_TEMP_DISABLE;
	tcc_temp_t         fan_upper = 16'sh012c, dz_lower = `TCC_TEMP_DISABLE, dz_upper = 16'sh0190;
	tcc_temp_t         g1 = 16'sh00fa, g2 = 16'sh00fa, g3 = 16'sh0064;
	tcc_temp_t         sensor1_temp, sensor2_temp, sensor3_temp, setpoint_internal;
	tcc_temp_t         s2_corrected, s3_corrected;
	logic [6:0]        tolerance_range = 7'h0f, alarm_range = 7'h14, power_demand = 7'h40;
	logic [6:0]        proportional_gain_entry = 7'h0a, integral_gain_entry = 7'h0a;
	logic [6:0]        derivative_gain_entry = 7'h0a, ramp_rate = 7'h00, fan_hyst = 7'h0a;
	logic [6:0]        s2_offset_mag = 7'h00, s3_offset_mag = 7'h00, fan_delay = 7'h04;
	logic [6:0]        dz_hyst = 7'h0a, pwm_limit;
	logic [9:0]        integral_clamp_entry = 10'h064;
	logic [7:0]        pwm_limit_entry = 8'h7f;
	logic [8:0]        supply_voltage, supply_lower = 9'h064, supply_upper = 9'h12c, gv = 9'h0f0;
	logic [5:0]        filter_seconds, proportional_gain, integral_gain, derivative_gain;
	logic [13:0]       integral_clamp;
	tcc_sensor_kind_t  sensor_kind;
	logic              use_set_value2, control_enable, power_out, range_error, supply_fault;
	logic              sensor_fault, limit_cfg_error, aux_out, dead_zone_inside, fan_on;
	int unsigned       on_cycles;
	int                n_mismatch = 0, check_count = 0;
	logic [5:0]        ft [6] = '{6'h01, 6'h02, 6'h05, 6'h0a, 6'h14, 6'h32};
	tcc_temp_t         dzv [4] = '{16'sh012c, 16'sh0096, 16'sh012c, 16'sh01c2};

	tcc_thermal_ctrl #(.RAMP_TICK_CYC(10), .SLOW_STEP_CYC(4), .FAN_UNIT_CYC(5))
		u_tcc_thermal_ctrl (.*);
	tcc_far_side u_tcc_far_side (.sys_clk(sys_clk), .t1_goal(g1), .t2_goal(g2), .t3_goal(g3),
		.volt_goal(gv), .power_out(power_out), .clr(clr), .s1(sensor1_temp), .s2(sensor2_temp),
		.s3(sensor3_temp), .volts(supply_voltage), .on_cycles(on_cycles));

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Counts on-clocks over a whole number of PWM periods so phase does not matter
	task automatic duty(input int n, input logic [15:0] exp);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(n);
		chk(16'(on_cycles), exp);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the roughly 13000 clocks of the tests
	initial begin
		#1000000;
		n_mismatch++;
		complete_run();
	end

	initial begin
		tick(10);
		rst = 1'b0;
		chk(filter_seconds, 16'h0001);
		foreach (ft[i]) begin
			filter_sel = 3'(i);
			sensor_sel = 2'(i % 3);
			tick(2);
			chk(filter_seconds, 16'(ft[i]));
			chk(sensor_kind, 16'(i % 3));
		end
		// Boundary entries of the gain, clamp and limit fields
		proportional_gain_entry = 7'h3f;
		integral_gain_entry = 7'h40;
		integral_clamp_entry = 10'h3e7;
		pwm_limit_entry = 8'h80;
		derivative_gain_entry = 7'h7f;
		tick(2);
		chk(proportional_gain, 16'h003f);
		chk(derivative_gain, 16'h0000);
		chk(integral_gain, 16'h0000);
		chk(integral_clamp, 16'h2706);
		chk(pwm_limit, 16'h0000);
		integral_clamp_entry = 10'h3e8;
		integral_gain_entry = 7'h21;
		pwm_limit_entry = 8'h7f;
		tick(2);
		chk(integral_clamp, 16'h0000);
		chk(integral_gain, 16'h0000);
		integral_clamp_entry = 10'h064;
		// Set point loads from the measurement, then ramps
		sample_valid = 1'b1;
		tick(1);
		sample_valid = 1'b0;
		chk(setpoint_internal, 16'h00fa);
		tick(3);
		chk(setpoint_internal, 16'h012c);
		ramp_rate = 7'h3c;
		set_value1 = 16'sh012e;
		tick(20);
		chk(setpoint_internal, 16'h012c);
		tick(12000);
		chk(setpoint_internal, 16'h012d);
		ramp_rate = 7'h00;
		set_value1 = 16'sh012c;
		tick(3);
		chk(setpoint_internal, 16'h012c);
		// Auxiliary input modes with the dead zone disabled
		for (int i = 0; i < 6; i++) begin
			aux_in_mode = tcc_aux_in_mode_t'(i / 2);
			aux_in = i[0];
			tick(3);
			chk(control_enable, 16'(i != 1 && i != 2));
			chk(use_set_value2, 16'(i == 5));
		end
		aux_in = 1'b0;
		duty(128, 16'h0040);
		config_mode = 1'b1;
		tick(3);
		chk(control_enable, 16'h0000);
		duty(128, 16'h0000);
		config_mode = 1'b0;
		pwm_limit_entry = 8'h00;
		tick(3);
		duty(128, 16'h0000);
		heater_mode = 1'b1;
		pwm_limit_entry = 8'h01;
		tick(3);
		duty(64, 16'h0020);
		heater_mode = 1'b0;
		pwm_limit_entry = 8'h7f;
		// Auxiliary output against a set point of 30.0
		for (int i = 0; i < 4; i++) begin
			aux_out_mode = tcc_aux_out_mode_t'(i[1]);
			g1 = i[0] ? 16'sh014a : 16'sh0136;
			tick(4);
			chk(aux_out, 16'(i[0] ^ i[1]));
		end
		// Range and supply faults clear by themselves
		g1 = 16'sh0708;
		tick(4);
		chk(range_error, 16'h0001);
		duty(128, 16'h0000);
		g1 = 16'shfd08;
		tick(4);
		chk(range_error, 16'h0001);
		g1 = 16'sh012c;
		tick(4);
		chk(range_error, 16'h0000);
		gv = 9'h032;
		tick(4);
		chk(supply_fault, 16'h0001);
		duty(128, 16'h0000);
		gv = 9'h140;
		tick(4);
		chk(supply_fault, 16'h0001);
		gv = 9'h0f0;
		tick(4);
		chk(supply_fault, 16'h0000);
		// Sensor limits: rejected band, disabled, enabled
		g2 = 16'sh0258;
		s2_limit = 16'shfce0;
		tick(4);
		chk(limit_cfg_error, 16'h0001);
		chk(sensor_fault, 16'h0000);
		s2_limit = `TCC_TEMP_DISABLE;
		tick(4);
		chk(limit_cfg_error, 16'h0000);
		chk(sensor_fault, 16'h0000);
		s2_limit = 16'sh01f4;
		tick(4);
		chk(sensor_fault, 16'h0001);
		s2_limit = `TCC_TEMP_DISABLE;
		g2 = 16'sh00fa;
		s2_offset_neg = 1'b1;
		s3_offset_neg = 1'b1;
		tick(4);
		chk(s2_corrected, 16'h00f9);
		chk(s3_corrected, 16'h0063);
		s2_offset_neg = 1'b0;
		s3_offset_neg = 1'b0;
		// Dead zone 20.0 to 40.0: inside, below, inside, above
		aux_in_mode = TCC_AUXIN_OFF;
		dz_lower = 16'sh00c8;
		foreach (dzv[i]) begin
			g2 = dzv[i];
			tick(5);
			chk(control_enable, 16'(i[0]));
			chk(use_set_value2, 16'(i == 3));
			chk(dead_zone_inside, 16'(!i[0]));
		end
		aux_in_mode = TCC_AUXIN_DUAL;
		tick(3);
		chk(use_set_value2, 16'h0000);
		// Fan waits 4 units of 5 clocks before following its request
		g3 = 16'sh0190;
		tick(12);
		chk(fan_on, 16'h0000);
		tick(25);
		chk(fan_on, 16'h0001);
		config_mode = 1'b1;
		tick(1);
		chk(fan_on, 16'h0000);
		config_mode = 1'b0;
		tick(2);
		complete_run();
	end
endmodule
